// ---- design/tbf_cfg.svh ----
`ifndef TBF_CFG_SVH
`define TBF_CFG_SVH
// ==========================================================
// sizes
`define TBF_INSTS          4
`define TBF_ARCS           8
`define TBF_ADDR_W         32
`define TBF_FIFO_DEPTH     8
// ==========================================================
// register byte offsets
`define TBF_OFF_CTRL       8'h00
`define TBF_OFF_STATUS     8'h04
// ==========================================================
// control fields
`define TBF_CTRL_INC_LSB   0
`define TBF_CTRL_EXC_LSB   8
`define TBF_CTRL_FERR_BIT  16
`define TBF_CTRL_FRST_BIT  17
`define TBF_CTRL_OVFC_BIT  18
`define TBF_CTRL_FOLW_BIT  19
`define TBF_CTRL_W         20
`define TBF_CTRL_RESET     20'h00000
// ==========================================================
// status fields
`define TBF_STAT_TA_BIT    0
`define TBF_STAT_GAP_BIT   1
`define TBF_STAT_EMPTY_BIT 2
`define TBF_STAT_FULL_BIT  3
`define TBF_TA_RESET       1'b0
`define TBF_GAP_RESET      1'b1
`endif

// ---- design/tbf_pkg.sv ----
`default_nettype none
`include "tbf_cfg.svh"
package tbf_pkg;
    typedef enum logic [1:0] {TBF_EXC_OTHER, TBF_EXC_SERROR, TBF_EXC_RESET} tbf_exc_e;
    typedef enum logic [1:0] {TBF_EL_TRACE_ON, TBF_EL_TARGET, TBF_EL_BLOCK, TBF_EL_EXC} tbf_el_e;
    typedef enum logic [1:0] {TBF_S_IDLE, TBF_S_ON, TBF_S_ADDR, TBF_S_MAIN} tbf_state_e;
    typedef struct packed {
        logic                                 is_exc;
        tbf_exc_e                             exc_kind;
        logic                                 cancel;
        logic                                 prohibited;
        logic                                 debug;
        logic [`TBF_INSTS-1:0]                inst_valid;
        logic [`TBF_INSTS-1:0][`TBF_ARCS-1:0] arc_match;
        logic [`TBF_ADDR_W-1:0]               addr;
    } tbf_item_s;
    typedef struct packed {
        tbf_el_e                kind;
        tbf_exc_e               exc_kind;
        logic [`TBF_ADDR_W-1:0] addr;
    } tbf_elem_s;
endpackage
`default_nettype wire

// ---- design/tbf_top.sv ----
// Contract
// - any included instruction includes whole block
// - block excluded only if all instructions excluded
// - partial exclude coverage may keep block
// - all instructions with high result traced
// - after gap, trace-on when result high
// - same-block low instructions may be traced
// - block following traced block may be traced
// - other low-result instructions not traced
// - exceptions update no comparator, match nothing
// - traced item outside prohibited sets active bit
// - untraced item outside prohibited clears active bit
// - canceled item restores previous active bit
// - exception traced while active bit set
// - debug or prohibited leaves active bit
// - overflow clears or keeps active bit
// - result is include and not exclude
// - forced system error and reset tracing
// - forced exception after gap: trace-on, target first
`default_nettype none
`include "tbf_cfg.svh"

// ==========================================================
// element fifo
module tbf_fifo #(
    parameter int W = 36,
    parameter int D = 8
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem [D];
    logic [W-1:0]  mem_next [D];
    logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
    logic [AW:0]   cnt_reg, cnt_next;
    logic          full_reg, full_next, empty_reg, empty_next;
    logic          push, pop;

    assign push      = in_valid & ~full_reg;
    assign pop       = out_ready & ~empty_reg;
    assign in_ready  = ~full_reg;
    assign out_valid = ~empty_reg;
    assign out_data  = mem[rd_reg];

    always_comb begin
        wr_next    = push ? AW'(wr_reg + 1'b1) : wr_reg;
        rd_next    = pop ? AW'(rd_reg + 1'b1) : rd_reg;
        cnt_next   = cnt_reg;
        if (push & ~pop) begin
            cnt_next = (AW+1)'(cnt_reg + 1'b1);
        end else if (pop & ~push) begin
            cnt_next = (AW+1)'(cnt_reg - 1'b1);
        end
        full_next  = (cnt_next == (AW+1)'(D));
        empty_next = (cnt_next == '0);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_reg    <= '0;
            rd_reg    <= '0;
            cnt_reg   <= '0;
            full_reg  <= 1'b0;
            empty_reg <= 1'b1;
        end else begin
            wr_reg    <= wr_next;
            rd_reg    <= rd_next;
            cnt_reg   <= cnt_next;
            full_reg  <= full_next;
            empty_reg <= empty_next;
        end
    end

    // storage has no reset: only entries counted by cnt_reg are ever read
    always_comb begin
        mem_next = mem;
        if (push) begin
            mem_next[wr_reg] = in_data;
        end
    end

    always_ff @(posedge hclk) begin
        mem <= mem_next;
    end
endmodule // tbf_fifo

// ==========================================================
// block filter top
module tbf_top
    import tbf_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        item_valid,
    output logic             item_ready,
    input  wire tbf_item_s   item_data,
    input  wire logic        buf_overflow,
    output logic             elem_valid,
    input  wire logic        elem_ready,
    output tbf_elem_s        elem_data,
    output logic             trace_active_state_bit
);
    localparam int EW = $bits(tbf_elem_s);

    // ======================================================
    // bus slave
    logic [`TBF_CTRL_W-1:0] ctrl_reg, ctrl_next;
    logic [31:0]            hrdata_reg, hrdata_next;
    logic                   wpend_reg, wpend_next;
    logic [7:0]             waddr_reg, waddr_next;
    logic                   ready_reg, ready_next, resp_reg, resp_next;
    logic                   take, fifo_in_ready, fifo_empty_s, fifo_full_s;
    logic                   ta_reg, gap_reg;
    logic [31:0]            ctrl_view, rd_val;

    // a transfer is taken only while the bus is ready
    assign take = hsel & hready & htrans[1];

    always_comb begin
        ctrl_next = ctrl_reg;
        if (wpend_reg && waddr_reg == `TBF_OFF_CTRL) begin
            ctrl_next = hwdata[`TBF_CTRL_W-1:0];
        end
        // read data sees a write still in its data phase
        ctrl_view = {{(32-`TBF_CTRL_W){1'b0}}, ctrl_next};
        rd_val    = 32'h00000000;
        unique case (haddr[7:0])
            `TBF_OFF_CTRL: rd_val = ctrl_view;
            `TBF_OFF_STATUS: begin
                rd_val[`TBF_STAT_TA_BIT]    = ta_reg;
                rd_val[`TBF_STAT_GAP_BIT]   = gap_reg;
                rd_val[`TBF_STAT_EMPTY_BIT] = fifo_empty_s;
                rd_val[`TBF_STAT_FULL_BIT]  = fifo_full_s;
            end
            default: rd_val = 32'h00000000;
        endcase
        hrdata_next = (take & ~hwrite) ? rd_val : hrdata_reg;
        wpend_next  = take & hwrite;
        waddr_next  = take ? haddr[7:0] : waddr_reg;
        // zero wait states, every response is OKAY
        ready_next  = 1'b1;
        resp_next   = 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg   <= `TBF_CTRL_RESET;
            hrdata_reg <= 32'h00000000;
            wpend_reg  <= 1'b0;
            waddr_reg  <= 8'h00;
            ready_reg  <= 1'b1;
            resp_reg   <= 1'b0;
        end else begin
            ctrl_reg   <= ctrl_next;
            hrdata_reg <= hrdata_next;
            wpend_reg  <= wpend_next;
            waddr_reg  <= waddr_next;
            ready_reg  <= ready_next;
            resp_reg   <= resp_next;
        end
    end

    assign hreadyout = ready_reg;
    assign hresp     = resp_reg;
    assign hrdata    = hrdata_reg;

    // ======================================================
    // per-instruction filter
    logic [`TBF_ARCS-1:0]  range_include_select, range_exclude_select;
    logic [`TBF_INSTS-1:0] instruction_filter_result;
    logic                  force_system_error_trace, force_reset_trace;

    assign range_include_select     = ctrl_reg[`TBF_CTRL_INC_LSB +: `TBF_ARCS];
    assign range_exclude_select     = ctrl_reg[`TBF_CTRL_EXC_LSB +: `TBF_ARCS];
    assign force_system_error_trace = ctrl_reg[`TBF_CTRL_FERR_BIT];
    assign force_reset_trace        = ctrl_reg[`TBF_CTRL_FRST_BIT];

    for (genvar g = 0; g < `TBF_INSTS; g++) begin : g_inst
        logic [`TBF_ARCS-1:0] m;
        logic                 inc, exc;
        // exceptions see no comparator hit at all
        assign m   = item_data.is_exc ? '0 : item_data.arc_match[g];
        assign inc = (|(m & range_include_select)) | ~(|range_include_select);
        assign exc = |(m & range_exclude_select);
        assign instruction_filter_result[g] = item_data.inst_valid[g] & inc & ~exc;
    end

    // ======================================================
    // trace decision for the offered item
    tbf_state_e state_reg, state_next;
    tbf_item_s  cur_reg, cur_next;
    logic       ta_next, ta_prev_reg, ta_prev_next, gap_next;
    logic       prev_inc_reg, prev_inc_next, in_rdy_reg, in_rdy_next;
    logic       blk_inc, forced, traced, accept, push;
    tbf_elem_s  push_el;

    assign accept = item_valid & in_rdy_reg;
    assign blk_inc = |instruction_filter_result;

    always_comb begin
        forced = item_data.is_exc & ~item_data.prohibited & (
                 (item_data.exc_kind == TBF_EXC_SERROR & force_system_error_trace) |
                 (item_data.exc_kind == TBF_EXC_RESET & force_reset_trace));
        // prohibited items are never traced, forced or not
        if (item_data.prohibited) begin
            traced = 1'b0;
        end else if (item_data.is_exc) begin
            traced = ta_reg | forced;
        end else begin
            // follow mode also keeps a low block right after an included one
            traced = blk_inc | (ctrl_reg[`TBF_CTRL_FOLW_BIT] & prev_inc_reg);
        end
    end

    // ======================================================
    // element sequencing and active bit update
    always_comb begin
        state_next    = state_reg;
        cur_next      = cur_reg;
        ta_next       = ta_reg;
        ta_prev_next  = ta_prev_reg;
        gap_next      = gap_reg;
        prev_inc_next = prev_inc_reg;
        push          = 1'b0;
        push_el       = '{kind: TBF_EL_BLOCK, exc_kind: cur_reg.exc_kind, addr: cur_reg.addr};
        unique case (state_reg)
            TBF_S_IDLE: begin
                if (accept) begin
                    cur_next = item_data;
                    if (item_data.cancel) begin
                        ta_next = ta_prev_reg;
                    end else begin
                        ta_prev_next = ta_reg;
                        if (!item_data.prohibited && !item_data.debug) begin
                            ta_next = traced;
                        end
                        if (!item_data.is_exc) begin
                            prev_inc_next = blk_inc & ~item_data.prohibited;
                        end
                        if (traced) begin
                            state_next = gap_reg ? TBF_S_ON : TBF_S_MAIN;
                            gap_next   = 1'b0;
                        end else begin
                            gap_next = 1'b1;
                        end
                    end
                end
            end
            TBF_S_ON: begin
                push         = 1'b1;
                push_el.kind = TBF_EL_TRACE_ON;
                if (fifo_in_ready) begin
                    state_next = cur_reg.is_exc ? TBF_S_ADDR : TBF_S_MAIN;
                end
            end
            TBF_S_ADDR: begin
                push         = 1'b1;
                push_el.kind = TBF_EL_TARGET;
                if (fifo_in_ready) begin
                    state_next = TBF_S_MAIN;
                end
            end
            TBF_S_MAIN: begin
                push         = 1'b1;
                push_el.kind = cur_reg.is_exc ? TBF_EL_EXC : TBF_EL_BLOCK;
                if (fifo_in_ready) begin
                    state_next = TBF_S_IDLE;
                end
            end
        endcase
        // an overflow in the same cycle as a take wins over its gap bit, and over its active bit only when TBF_CTRL_OVFC_BIT is set
        if (buf_overflow) begin
            gap_next = 1'b1;
            if (ctrl_reg[`TBF_CTRL_OVFC_BIT]) begin
                ta_next = 1'b0;
            end
        end
        in_rdy_next = (state_next == TBF_S_IDLE);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg    <= TBF_S_IDLE;
            cur_reg      <= '0;
            ta_reg       <= `TBF_TA_RESET;
            ta_prev_reg  <= `TBF_TA_RESET;
            gap_reg      <= `TBF_GAP_RESET;
            prev_inc_reg <= 1'b0;
            in_rdy_reg   <= 1'b0;
        end else begin
            state_reg    <= state_next;
            cur_reg      <= cur_next;
            ta_reg       <= ta_next;
            ta_prev_reg  <= ta_prev_next;
            gap_reg      <= gap_next;
            prev_inc_reg <= prev_inc_next;
            in_rdy_reg   <= in_rdy_next;
        end
    end

    assign item_ready             = in_rdy_reg;
    assign trace_active_state_bit = ta_reg;

    // ======================================================
    // element fifo
    logic      fifo_out_valid, fifo_pop, ovld_reg, ovld_next;
    tbf_elem_s fifo_out_data, odat_reg, odat_next;

    tbf_fifo #(
        .W (EW),
        .D (`TBF_FIFO_DEPTH)
    ) u_fifo (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (push_el),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out_data)
    );

    // ======================================================
    // output register stage
    always_comb begin
        // refill in the same cycle the sink takes the held element
        fifo_pop  = fifo_out_valid & (~ovld_reg | elem_ready);
        ovld_next = ovld_reg;
        odat_next = odat_reg;
        if (fifo_pop) begin
            ovld_next = 1'b1;
            odat_next = fifo_out_data;
        end else if (elem_ready) begin
            ovld_next = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ovld_reg <= 1'b0;
            odat_reg <= '0;
        end else begin
            ovld_reg <= ovld_next;
            odat_reg <= odat_next;
        end
    end

    assign elem_valid   = ovld_reg;
    assign elem_data    = odat_reg;
    assign fifo_empty_s = ~ovld_reg & ~fifo_out_valid;
    assign fifo_full_s  = ~fifo_in_ready;
endmodule // tbf_top
`default_nettype wire

// ---- verif/tb_trace_block_filter_state.sv ----
`default_nettype none
`include "tbf_cfg.svh"
// ==========================================================
// testbench top
module tb_trace_block_filter_state
    import tbf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] A_CTRL = 32'(`TBF_OFF_CTRL);
    localparam logic [31:0] A_STAT = 32'(`TBF_OFF_STATUS);
    logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, r;
    logic        hreadyout, hresp, item_valid, item_ready, elem_valid, ta, lc;
    logic        buf_overflow = 1'h0, elem_ready = 1'h0, stall = 1'h1, chk_on = 1'h1;
    logic        exp_ta = 1'h0, prev_ta = 1'h0, gap = 1'h1, prev_inc = 1'h0;
    logic [19:0] ctrl = 20'h0;
    tbf_item_s   item_data, it;
    tbf_elem_s   elem_data;
    tbf_el_e     exp_q[$];
    int          seed = 60, n_mismatch = 0, checked = 0;
    always #2 hclk = ~hclk;
    tbf_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .item_valid(item_valid),
        .item_ready(item_ready), .item_data(item_data), .buf_overflow(buf_overflow),
        .elem_valid(elem_valid), .elem_ready(elem_ready), .elem_data(elem_data),
        .trace_active_state_bit(ta));
    tbf_core_model u_core (.hclk(hclk), .item_valid(item_valid), .item_ready(item_ready),
        .item_data(item_data));
    // ==========================================================
    // helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        if (n_mismatch == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'h1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= wr;
        do @(posedge hclk); while (!hreadyout);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (!hreadyout);
        rd = hrdata;
        chk(hresp, 1'h0);
    endtask
    function automatic logic traced_f(input tbf_item_s i, input logic [19:0] c, input logic a);
        logic hit;
        hit = 1'h0;
        if (i.prohibited) return 1'h0;
        if (i.is_exc) return a || (i.exc_kind == TBF_EXC_SERROR && c[16])
            || (i.exc_kind == TBF_EXC_RESET && c[17]);
        for (int n = 0; n < `TBF_INSTS; n++) begin
            if (i.inst_valid[n] && (|(i.arc_match[n] & c[7:0]) || c[7:0] == 8'h0)
                && !(|(i.arc_match[n] & c[15:8]))) hit = 1'h1;
        end
        return hit;
    endfunction
    task automatic item(input tbf_item_s i);
        logic t;
        t = traced_f(i, ctrl, exp_ta)
            || (!i.is_exc && !i.prohibited && ctrl[19] && prev_inc);
        if (i.cancel) begin
            exp_ta = prev_ta;
        end else begin
            prev_ta = exp_ta;
            if (!i.is_exc) prev_inc = traced_f(i, ctrl, 1'h0);
            if (!i.prohibited && !i.debug) exp_ta = t;
            if (t && gap) exp_q.push_back(TBF_EL_TRACE_ON);
            if (t && gap && i.is_exc) exp_q.push_back(TBF_EL_TARGET);
            if (t) exp_q.push_back(i.is_exc ? TBF_EL_EXC : TBF_EL_BLOCK);
            gap = !t;
        end
        u_core.send(i, $random(seed) & 3);
        @(negedge hclk);
        chk(ta, exp_ta);
    endtask
    // ==========================================================
    // element sink with random stalls and in-order compare
    always @(posedge hclk) begin
        elem_ready <= !stall && ($random(seed) % 4 != 0);
        if (chk_on && elem_valid && elem_ready) begin
            chk(exp_q.size() > 0, 1'h1);
            chk(elem_data.kind, exp_q.pop_front());
        end
    end
    // ==========================================================
    // main sequence
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        ahb(1'h0, A_CTRL, 32'h0);
        chk(rd, 32'h0);
        ahb(1'h1, A_STAT, 32'hF);
        ahb(1'h0, A_STAT, 32'h0);
        chk(rd, 32'h6);
        ahb(1'h0, 32'h8, 32'h0);
        chk(rd, 32'h0);
        it = '0;
        it.inst_valid = 4'h1;
        repeat (9) item(it);
        ahb(1'h0, A_STAT, 32'h0);
        chk(rd, 32'h9);
        chk(item_ready, 1'h0);
        stall <= 1'h0;
        lc = 1'h0;
        for (int p = 0; p < 6; p++) begin
            ctrl = (p == 0) ? 20'h30000 : 20'($random(seed)) & 20'hFFFFF;
            ahb(1'h1, A_CTRL, {12'h0, ctrl});
            ahb(1'h0, A_CTRL, 32'h0);
            chk(rd, {12'h0, ctrl});
            for (int k = 0; k < 40; k++) begin
                it.arc_match  = $random(seed);
                it.inst_valid = $random(seed);
                it.addr       = $random(seed);
                r             = $random(seed);
                it.is_exc     = r[1:0] == 2'h0;
                it.exc_kind   = tbf_exc_e'(r[3:2] % 3);
                it.prohibited = r[6:4] == 3'h0;
                it.cancel     = r[9:7] == 3'h0 && !lc;
                lc            = it.cancel;
                if (it.inst_valid == 4'h0) it.inst_valid = 4'h8;
                item(it);
            end
        end
        repeat (60) @(negedge hclk);
        chk(exp_q.size(), 32'h0);
        chk_on = 1'h0;
        it = '0;
        it.inst_valid = 4'h2;
        for (int m = 0; m < 2; m++) begin
            ctrl = m ? 20'h00000 : 20'h40000;
            ahb(1'h1, A_CTRL, {12'h0, ctrl});
            item(it);
            @(posedge hclk);
            buf_overflow <= 1'h1;
            @(posedge hclk);
            buf_overflow <= 1'h0;
            @(negedge hclk);
            exp_ta = 1'(m);
            chk(ta, exp_ta);
        end
        ctrl = 20'h0FF00;
        ahb(1'h1, A_CTRL, {12'h0, ctrl});
        it.debug = 1'h1;
        it.arc_match = '1;
        item(it);
        end_sim();
    end
    // ==========================================================
    // watchdog: far beyond the thousand or so cycles the run needs
    initial begin
        #100000;
        n_mismatch++;
        end_sim();
    end
endmodule // tb_trace_block_filter_state
bind tbf_top tbf_assertions u_chk (.hclk, .hresetn, .item_valid, .item_ready, .item_data,
    .buf_overflow, .elem_valid, .elem_ready, .elem_data, .trace_active_state_bit);
`default_nettype wire

// ---- verif/tbf_assertions.sv ----
`default_nettype none
// ==========================================================
// port checker
module tbf_assertions
    import tbf_pkg::*;
(
    input wire logic      hclk,
    input wire logic      hresetn,
    input wire logic      item_valid,
    input wire logic      item_ready,
    input wire tbf_item_s item_data,
    input wire logic      buf_overflow,
    input wire logic      elem_valid,
    input wire logic      elem_ready,
    input wire tbf_elem_s elem_data,
    input wire logic      trace_active_state_bit
);
    timeunit 1ns;
    timeprecision 1ps;
    logic    take, pop, ta, prev_ta_reg;
    tbf_el_e last_reg;
    assign take = item_valid && item_ready;
    assign pop  = elem_valid && elem_ready;
    assign ta   = trace_active_state_bit;
    // ==========================================================
    // history of the active bit and of popped kinds
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_ta_reg <= 1'h0;
            last_reg    <= TBF_EL_BLOCK;
        end else begin
            if (take && !item_data.cancel) prev_ta_reg <= ta;
            if (pop) last_reg <= elem_data.kind;
        end
    end
    default clocking dc @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // ==========================================================
    // properties
    item_stall_a: assert property (take && item_data.is_exc && !item_data.cancel
        && !item_data.prohibited && ta |=> !item_ready)
        else $error("item_ready high after a traced exception was taken");
    exc_traced_a: assert property (take && item_data.is_exc && !item_data.cancel
        && !item_data.prohibited && !item_data.debug && !buf_overflow && ta
        |=> ta ##[0:4] elem_valid) else $error("exception not traced");
    hold_bit_a: assert property (take && (item_data.debug || item_data.prohibited)
        && !item_data.cancel && !buf_overflow |=> $stable(ta))
        else $error("active bit changed in debug or prohibited");
    cancel_restore_a: assert property (take && item_data.cancel && !buf_overflow
        |=> ta == prev_ta_reg) else $error("cancel did not restore the active bit");
    ovf_no_rise_a: assert property (buf_overflow && !take |=> !$rose(ta))
        else $error("overflow set the active bit");
    rise_push_a: assert property ((take && !item_data.cancel) ##1 $rose(ta)
        |-> ##[0:4] elem_valid) else $error("active bit set without output");
    on_order_a: assert property (pop && last_reg == TBF_EL_TRACE_ON
        |-> elem_data.kind inside {TBF_EL_TARGET, TBF_EL_BLOCK})
        else $error("bad element after trace-on");
    target_exc_a: assert property (pop && last_reg == TBF_EL_TARGET
        |-> elem_data.kind == TBF_EL_EXC) else $error("target not followed by exception");
    cover property (take && item_data.is_exc && ta);
    cover property (take && item_data.cancel);
    cover property (pop && elem_data.kind == TBF_EL_TARGET);
endmodule // tbf_assertions
`default_nettype wire

// ---- verif/tbf_core_model.sv ----
`default_nettype none
// ==========================================================
// core side: offers one item and holds it until taken
module tbf_core_model
    import tbf_pkg::*;
(
    input  wire logic hclk,
    output logic      item_valid,
    input  wire logic item_ready,
    output tbf_item_s item_data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        item_valid = 1'h0;
        item_data  = '0;
    end
    task automatic send(input tbf_item_s it, input int dly);
        repeat (dly + 1) @(posedge hclk);
        item_valid <= 1'h1;
        item_data  <= it;
        do @(posedge hclk); while (!item_ready);
        item_valid <= 1'h0;
        item_data  <= ~it;
    endtask
endmodule // tbf_core_model
`default_nettype wire
